// >>> core/gom_gpio_output_source_mux.sv
// Summary of operation
// - Source field bits 4:2 picks receive port 0-3, device status or transmit port.
// - Receive source, select 000-011 drives forwarded remote values 0 to 3.
// - Receive source, select 100 gives lock, 101 gives pass.
// - Receive source, select 110 gives frame-valid, 111 gives line-valid.
// - Status source, select 000 drives the software-written local level bit.
// - Status source, select 001 gives OR of lock over enabled receive ports.
// - Status source, selects 010 and 011 give AND of pass over enabled ports.
// - Status source, selects 101 to 111 are reserved.
// - Transmit source, select 000 ANDs chosen ports' pass, 001 ORs them.
// - Transmit source, 010 high while frame sent, 011 while line sent.
// - Transmit source, 100 synchronized, 101 transmit interrupt, 110 and 111 reserved.
// - Bit 0 enables the pin driver, cleared by reset.
// - Bit 1 holds the software level driven in local-value mode.
// - Frame sync select 100 belongs to the neighbour pin only; here it is reserved.
`timescale 1ns/1ps
`default_nettype none
module gom_gpio_output_source_mux (
	input  wire logic                              sys_clk_i,
	input  wire logic                              rst_b_i,
	input  wire logic [gom_pkg::ADDR_W-1:0]        avs_address_i,
	input  wire logic                              avs_read_i,
	input  wire logic                              avs_write_i,
	input  wire logic [gom_pkg::DATA_W-1:0]        avs_writedata_i,
	input  wire logic [3:0]                        avs_byteenable_i,
	output logic      [gom_pkg::DATA_W-1:0]        avs_readdata_o,
	output logic      [1:0]                        avs_response_o,
	output logic                                   avs_waitrequest_o,
	input  wire gom_pkg::gom_rx_port_type [3:0]    rx_port_i,
	input  wire gom_pkg::gom_tx_port_type          tx_port_i,
	input  wire logic                              frame_sync_pulse_i,
	output logic                                   pin_out_o,
	output logic                                   pin_oe_o
);

	function automatic logic [gom_pkg::ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx[5:0], 2'b00};
	endfunction : byte_addr

	// An empty mask gives low for both reductions.
	function automatic logic and_over_mask(input logic [3:0] bits, input logic [3:0] mask);
		and_over_mask = (mask != 4'h0) && ((bits | ~mask) == 4'hf);
	endfunction : and_over_mask

	function automatic logic or_over_mask(input logic [3:0] bits, input logic [3:0] mask);
		or_over_mask = (bits & mask) != 4'h0;
	endfunction : or_over_mask

	logic [7:0]                 pin_ctl_q;
	logic [3:0]                 rx_en_q;
	logic [3:0]                 tx_sel_q;
	logic                       wait_q;
	logic [gom_pkg::DATA_W-1:0] rdata_q;
	logic [1:0]                 resp_q;
	logic                       pin_out_q;
	logic                       pin_oe_q;

	logic                       req;
	logic                       accept;
	logic                       hit_ctl;
	logic                       hit_rx_en;
	logic                       hit_tx_sel;
	logic                       hit_status;
	logic                       hit_any;
	logic [gom_pkg::DATA_W-1:0] rdata_d;
	logic [3:0]                 lock_vec;
	logic [3:0]                 pass_vec;
	logic [2:0]                 sel;
	logic [1:0]                 port;
	gom_pkg::gom_src_type       src;
	logic                       level;

	assign req        = avs_read_i | avs_write_i;
	assign accept     = req & ~wait_q;
	assign hit_ctl    = avs_address_i == byte_addr(gom_pkg::IDX_PIN_CTL);
	assign hit_rx_en  = avs_address_i == byte_addr(gom_pkg::IDX_RX_EN);
	assign hit_tx_sel = avs_address_i == byte_addr(gom_pkg::IDX_TX_SEL);
	assign hit_status = avs_address_i == byte_addr(gom_pkg::IDX_STATUS);
	assign hit_any    = hit_ctl | hit_rx_en | hit_tx_sel | hit_status;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lock_vec[i] = rx_port_i[i].lock;
			pass_vec[i] = rx_port_i[i].pass;
		end
	end

	assign sel  = pin_ctl_q[gom_pkg::SEL_MSB:gom_pkg::SEL_LSB];
	assign src  = gom_pkg::gom_src_type'(pin_ctl_q[gom_pkg::SRC_MSB:gom_pkg::SRC_LSB]);
	assign port = pin_ctl_q[gom_pkg::SRC_LSB+1:gom_pkg::SRC_LSB];

	always_comb begin
		level = 1'b0;
		case (src)
			gom_pkg::SRC_RX0, gom_pkg::SRC_RX1,
			gom_pkg::SRC_RX2, gom_pkg::SRC_RX3: begin
				case (sel)
					gom_pkg::RX_SEL_LOCK: level = rx_port_i[port].lock;
					gom_pkg::RX_SEL_PASS: level = rx_port_i[port].pass;
					gom_pkg::RX_SEL_FV:   level = rx_port_i[port].frame_valid;
					gom_pkg::RX_SEL_LV:   level = rx_port_i[port].line_valid;
					default: level = rx_port_i[port].remote_gpio[sel[1:0]];
				endcase
			end
			gom_pkg::SRC_STATUS: begin
				case (sel)
					gom_pkg::DEV_SEL_VAL:      level = pin_ctl_q[gom_pkg::VAL_BIT];
					gom_pkg::DEV_SEL_LOCK_OR:  level = or_over_mask(lock_vec, rx_en_q);
					gom_pkg::DEV_SEL_PASS_AND: level = and_over_mask(pass_vec, rx_en_q);
					gom_pkg::DEV_SEL_PASS_AN2: level = and_over_mask(pass_vec, rx_en_q);
					// Frame sync is not routed to this pin, code 100 stays low.
					default: level = 1'b0;
				endcase
			end
			gom_pkg::SRC_TX0: begin
				case (sel)
					gom_pkg::TX_SEL_PASS_AND: level = and_over_mask(pass_vec, tx_sel_q);
					gom_pkg::TX_SEL_PASS_OR:  level = or_over_mask(pass_vec, tx_sel_q);
					gom_pkg::TX_SEL_FRAME:    level = tx_port_i.frame_active;
					gom_pkg::TX_SEL_LINE:     level = tx_port_i.line_active;
					gom_pkg::TX_SEL_SYNC:     level = tx_port_i.synced;
					gom_pkg::TX_SEL_IRQ:      level = tx_port_i.irq;
					default: level = 1'b0;
				endcase
			end
			default: level = 1'b0;
		endcase
	end

	// Pin driver; the level is forced low whenever the driver is off.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			pin_oe_q  <= 1'b0;
			pin_out_q <= 1'b0;
		end else begin
			pin_oe_q  <= pin_ctl_q[gom_pkg::EN_BIT];
			pin_out_q <= pin_ctl_q[gom_pkg::EN_BIT] & level;
		end
	end

	// Bus handshake: one wait cycle, then the access completes.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~(req & wait_q);
		end
	end

	always_comb begin
		rdata_d = '0;
		if (hit_ctl) begin
			rdata_d[7:0] = pin_ctl_q;
		end else if (hit_rx_en) begin
			rdata_d[3:0] = rx_en_q;
		end else if (hit_tx_sel) begin
			rdata_d[3:0] = tx_sel_q;
		end else if (hit_status) begin
			rdata_d[0]     = pin_oe_q;
			rdata_d[1]     = pin_out_q;
			rdata_d[2]     = level;
			rdata_d[3]     = frame_sync_pulse_i;
			rdata_d[11:8]  = lock_vec;
			rdata_d[15:12] = pass_vec;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
			resp_q  <= gom_pkg::RESP_OKAY;
		end else if (req & wait_q) begin
			rdata_q <= avs_read_i ? rdata_d : '0;
			resp_q  <= hit_any ? gom_pkg::RESP_OKAY : gom_pkg::RESP_SLVERR;
		end
	end

	// Writes land on the completing edge, low byte lane only.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			pin_ctl_q <= gom_pkg::PIN_CTL_RST;
			rx_en_q   <= gom_pkg::RX_EN_RST;
			tx_sel_q  <= gom_pkg::TX_SEL_RST;
		end else if (accept && avs_write_i && avs_byteenable_i[0]) begin
			if (hit_ctl) begin
				pin_ctl_q <= avs_writedata_i[7:0];
			end
			if (hit_rx_en) begin
				rx_en_q <= avs_writedata_i[3:0];
			end
			if (hit_tx_sel) begin
				tx_sel_q <= avs_writedata_i[3:0];
			end
		end
	end

	assign avs_readdata_o    = rdata_q;
	assign avs_response_o    = resp_q;
	assign avs_waitrequest_o = wait_q;
	assign pin_out_o         = pin_out_q;
	assign pin_oe_o          = pin_oe_q;

endmodule : gom_gpio_output_source_mux
`default_nettype wire

// >>> core/gom_pkg.sv
`default_nettype none
package gom_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_PIN_CTL = 8'h15;
	localparam logic [7:0] IDX_RX_EN   = 8'h20;
	localparam logic [7:0] IDX_TX_SEL  = 8'h21;
	localparam logic [7:0] IDX_STATUS  = 8'h22;

	// Field positions of pin5_output_control.
	localparam int unsigned SEL_MSB = 7;
	localparam int unsigned SEL_LSB = 5;
	localparam int unsigned SRC_MSB = 4;
	localparam int unsigned SRC_LSB = 2;
	localparam int unsigned VAL_BIT = 1;
	localparam int unsigned EN_BIT  = 0;

	// Reset values.
	localparam logic [7:0] PIN_CTL_RST = 8'h00;
	localparam logic [3:0] RX_EN_RST   = 4'hf;
	localparam logic [3:0] TX_SEL_RST  = 4'hf;

	// Avalon-MM response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_RX0    = 3'b000,
		SRC_RX1    = 3'b001,
		SRC_RX2    = 3'b010,
		SRC_RX3    = 3'b011,
		SRC_STATUS = 3'b100,
		SRC_RSV5   = 3'b101,
		SRC_TX0    = 3'b110,
		SRC_RSV7   = 3'b111
	} gom_src_type;

	// Select codes with a receive port as source.
	localparam logic [2:0] RX_SEL_LOCK = 3'b100;
	localparam logic [2:0] RX_SEL_PASS = 3'b101;
	localparam logic [2:0] RX_SEL_FV   = 3'b110;
	localparam logic [2:0] RX_SEL_LV   = 3'b111;

	// Select codes with device status as source.
	localparam logic [2:0] DEV_SEL_VAL      = 3'b000;
	localparam logic [2:0] DEV_SEL_LOCK_OR  = 3'b001;
	localparam logic [2:0] DEV_SEL_PASS_AND = 3'b010;
	localparam logic [2:0] DEV_SEL_PASS_AN2 = 3'b011;

	// Select codes with the transmit port as source.
	localparam logic [2:0] TX_SEL_PASS_AND = 3'b000;
	localparam logic [2:0] TX_SEL_PASS_OR  = 3'b001;
	localparam logic [2:0] TX_SEL_FRAME    = 3'b010;
	localparam logic [2:0] TX_SEL_LINE     = 3'b011;
	localparam logic [2:0] TX_SEL_SYNC     = 3'b100;
	localparam logic [2:0] TX_SEL_IRQ      = 3'b101;

	typedef struct packed {
		logic [3:0] remote_gpio;
		logic       lock;
		logic       pass;
		logic       frame_valid;
		logic       line_valid;
	} gom_rx_port_type;

	typedef struct packed {
		logic frame_active;
		logic line_active;
		logic synced;
		logic irq;
	} gom_tx_port_type;

endpackage : gom_pkg
`default_nettype wire

// >>> testbench/gom_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gom_properties (
	input wire logic                           sys_clk_i,
	input wire logic                           rst_b_i,
	input wire logic [7:0]                     avs_address_i,
	input wire logic                           avs_write_i,
	input wire logic [31:0]                    avs_writedata_i,
	input wire logic [3:0]                     avs_byteenable_i,
	input wire logic                           avs_waitrequest_o,
	input wire gom_pkg::gom_rx_port_type [3:0] rx_port_i,
	input wire gom_pkg::gom_tx_port_type       tx_port_i,
	input wire logic                           pin_out_o,
	input wire logic                           pin_oe_o
);
	logic [7:0] ctl_q;
	logic [3:0] rxen_q, txs_q, lk, ps;
	logic [2:0] sr, sl;
	logic       en, wr;
	assign sr = ctl_q[4:2];
	assign sl = ctl_q[7:5];
	assign en = ctl_q[0];
	assign wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lk[i] = rx_port_i[i].lock;
			ps[i] = rx_port_i[i].pass;
		end
	end
	// Shadow copy of the registers, so the pin level can be predicted.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			ctl_q <= 8'h00;
			rxen_q <= 4'hf;
			txs_q <= 4'hf;
		end else if (wr) begin
			case (avs_address_i)
				8'h54: ctl_q <= avs_writedata_i[7:0];
				8'h80: rxen_q <= avs_writedata_i[3:0];
				8'h84: txs_q <= avs_writedata_i[3:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence ctl_write;
		wr && avs_address_i == 8'h54;
	endsequence
	a_en_write: assert property (ctl_write |-> ##2 pin_oe_o == $past(avs_writedata_i[0], 2))
		else $error("pin enable does not follow control write");
	a_rx_remote: assert property ($past(en && !sr[2] && !sl[2]) |->
		pin_out_o == $past(rx_port_i[sr[1:0]][{1'b1, sl[1:0]}])) else $error("remote level wrong");
	a_rx_status: assert property ($past(en && !sr[2] && sl[2]) |->
		pin_out_o == $past(rx_port_i[sr[1:0]][~sl[1:0]])) else $error("port status wrong");
	a_dev_level: assert property ($past(en && sr == 3'h4 && sl == 3'h0) |->
		pin_out_o == $past(ctl_q[1])) else $error("local level wrong");
	a_lock_or: assert property (en && sr == 3'h4 && sl == 3'h1 |=>
		pin_out_o == $past(|(lk & rxen_q))) else $error("lock OR wrong");
	a_pass_and: assert property (en && sr == 3'h4 && sl[2:1] == 2'b01 |=>
		pin_out_o == $past(rxen_q != 4'h0 && &(ps | ~rxen_q))) else $error("pass AND wrong");
	a_tx_pass: assert property ($past(en && sr == 3'h6 && sl[2:1] == 2'b00) |->
		pin_out_o == $past(sl[0] ? |(ps & txs_q) : txs_q != 4'h0 && &(ps | ~txs_q)))
		else $error("transmit pass wrong");
	a_tx_video: assert property (en && sr == 3'h6 && sl inside {[3'h2:3'h5]} |=>
		pin_out_o == $past(tx_port_i[3'h5 - sl])) else $error("transmit status wrong");
	a_rsv_low: assert property (en && (sr[2] && sr[0] || sr == 3'h4 && sl[2] ||
		sr == 3'h6 && sl[2:1] == 2'b11) |=> !pin_out_o) else $error("reserved code not low");
	a_oe_gates: assert property (!pin_oe_o |-> !pin_out_o)
		else $error("pin driven while disabled");
endmodule : gom_properties
`default_nettype wire

// >>> testbench/gom_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module gom_pin_load (
	input  wire logic drv_i,
	input  wire logic oe_i,
	output logic      pin_o
);
	// A pull-up sets the level whenever the device lets the pin go.
	assign pin_o = oe_i ? drv_i : 1'b1;
endmodule : gom_pin_load
`default_nettype wire

// >>> testbench/gom_gpio_output_source_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gom_gpio_output_source_mux_tb;
	logic                           sys_clk_i = 1'b0;
	logic                           rst_b_i = 1'b0;
	logic [7:0]                     adr = 8'h00;
	logic                           rd = 1'b0;
	logic                           wr = 1'b0;
	logic [31:0]                    wd = 32'h0;
	logic [3:0]                     be = 4'hf;
	gom_pkg::gom_rx_port_type [3:0] rx = 32'h0;
	gom_pkg::gom_tx_port_type       tx = 4'h0;
	logic                           fs = 1'b0;
	logic [31:0]                    rdata, got, r;
	logic [1:0]                     resp, gresp;
	logic                           wait_o, pout, poe, pin;
	logic [3:0]                     rxen, txs;
	logic [7:0]                     c;
	integer                         seed = 48, error_cnt = 0, checks = 0;
	always #2 sys_clk_i = ~sys_clk_i;
	gom_gpio_output_source_mux dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_response_o(resp),
		.avs_waitrequest_o(wait_o), .rx_port_i(rx), .tx_port_i(tx),
		.frame_sync_pulse_i(fs), .pin_out_o(pout), .pin_oe_o(poe));
	gom_pin_load load (.drv_i(pout), .oe_i(poe), .pin_o(pin));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		int n;
		@(posedge sys_clk_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		be <= b;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (wait_o !== 1'b0 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			$display("ERROR %0t bus hang", $time);
			tally_and_finish;
		end
		got = rdata;
		gresp = resp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	function automatic logic expf(input logic [7:0] k);
		logic [3:0] lk, ps, st, t6;
		logic       v;
		for (int i = 0; i < 4; i++) begin
			lk[i] = rx[i].lock;
			ps[i] = rx[i].pass;
		end
		st = {rx[k[3:2]].line_valid, rx[k[3:2]].frame_valid, rx[k[3:2]].pass, rx[k[3:2]].lock};
		t6 = {tx.irq, tx.synced, tx.line_active, tx.frame_active};
		case (k[4:2])
			3'h4: v = k[7:5] == 3'h0 ? k[1] : k[7:5] == 3'h1 ? |(lk & rxen) :
				k[7:6] == 2'b01 ? (rxen != 4'h0 && &(ps | ~rxen)) : 1'b0;
			3'h6: v = k[7:6] == 2'b00 ? (k[5] ? |(ps & txs) : txs != 4'h0 && &(ps | ~txs)) :
				k[7:5] < 3'h6 ? t6[k[6:5] - 2'h2] : 1'b0;
			3'h5, 3'h7: v = 1'b0;
			default: v = k[7] ? st[k[6:5]] : rx[k[3:2]].remote_gpio[k[6:5]];
		endcase
		return k[0] & v;
	endfunction : expf
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		bus(1'b0, 8'h54, 32'h0, 4'hf);
		chk(got, 32'h0);
		chk(poe, 1'b0);
		bus(1'b0, 8'h10, 32'h0, 4'hf);
		chk(got, 32'h0);
		chk({30'h0, gresp}, 32'h2);
		$display("reset test done");
		for (int s = 0; s < 64; s++) begin
			r = $random(seed);
			rxen = (s % 9 == 0) ? 4'h0 : r[3:0];
			txs = (s % 7 == 0) ? 4'h0 : r[7:4];
			c = {s[2:0], s[5:3], r[8], s % 5 != 0};
			bus(1'b1, 8'h80, {28'h0, rxen}, 4'hf);
			bus(1'b1, 8'h84, {28'h0, txs}, 4'hf);
			bus(1'b1, 8'h54, {24'h0, c}, 4'hf);
			repeat (4) begin
				@(posedge sys_clk_i);
				rx <= $random(seed);
				r = $random(seed);
				tx <= r[3:0];
				fs <= r[4];
				@(posedge sys_clk_i);
				#1;
				chk(pout, expf(c));
				chk(pin, c[0] ? expf(c) : 1'b1);
			end
		end
		bus(1'b0, 8'h80, 32'h0, 4'hf);
		chk(got, {28'h0, rxen});
		chk({30'h0, gresp}, 32'h0);
		bus(1'b0, 8'h84, 32'h0, 4'hf);
		chk(got, {28'h0, txs});
		$display("sweep test done");
		bus(1'b1, 8'h54, 32'hff, 4'h0);
		bus(1'b0, 8'h54, 32'h0, 4'hf);
		chk(got, {24'h0, c});
		$display("byte enable test done");
		tally_and_finish;
	end
endmodule : gom_gpio_output_source_mux_tb
bind gom_gpio_output_source_mux gom_properties props (.*);
`default_nettype wire
